// *** core/sewid_core.v ***
// instruction engine of an spi eeprom: page write, identification page, lock
`timescale 1ns/1ps
`include "sewid_map.vh"
module sewid_core #(
  parameter [`SEWID_TW_W-1:0] TW_CYC = `SEWID_TW_CYC
) (
  // clock and reset
  input  wire                    ref_clk_i,
  input  wire                    rst_i,
  // spi pins
  input  wire                    cs_n_i,
  input  wire                    sclk_i,
  input  wire                    mosi_i,
  output reg                     miso_o,
  output wire                    miso_oe_o,
  // nonvolatile status bits held by the store
  input  wire                    protect_size_hi_i,
  input  wire                    protect_size_lo_i,
  input  wire                    status_lock_bit_i,
  input  wire                    id_locked_i,
  // read port of the store
  output reg                     rd_id_o,
  output reg  [`SEWID_ARR_W-1:0] rd_addr_o,
  input  wire [7:0]              rd_data_i,
  // staged bytes and write cycle towards the store
  output reg                     stg_valid_o,
  output reg                     stg_id_o,
  output reg  [`SEWID_ARR_W-1:0] stg_addr_o,
  output reg  [`SEWID_ARR_W-3:0] stg_group_o,
  output reg  [7:0]              stg_data_o,
  output reg                     stg_abort_o,
  output reg                     wr_commit_o,
  output wire                    wr_erase_o,
  output wire                    wr_prog_o,
  output reg                     id_lock_set_o,
  // status
  output wire                    write_busy_flag_o,
  output reg                     write_permit_latch_o
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OPC   = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDOUT = 3'h4;
  localparam [2:0] ST_SKIP  = 3'h5;

  localparam [2:0] K_ARR  = 3'h0;
  localparam [2:0] K_IDW  = 3'h1;
  localparam [2:0] K_LOCK = 3'h2;
  localparam [2:0] K_IDR  = 3'h3;
  localparam [2:0] K_LST  = 3'h4;
  localparam [2:0] K_STAT = 3'h5;

  // true when the 19-bit address falls in the area the protect bits cover
  function prot_hit;
    input [1:0] bp;
    input [1:0] top;
    begin
      case (bp)
        `SEWID_BP_NONE:    prot_hit = 1'b0;
        `SEWID_BP_QUARTER: prot_hit = (top == 2'h3);
        `SEWID_BP_HALF:    prot_hit = top[1];
        default:           prot_hit = 1'b1;
      endcase
    end
  endfunction

  // pin synchronisers; the second stage feeds logic, and a third stage on select and clock is used only to find edges
  reg        cs_m;
  reg        cs_s;
  reg        cs_p;
  reg        ck_m;
  reg        ck_s;
  reg        ck_p;
  reg        di_m;
  reg        di_s;

  reg  [2:0]              state;
  reg  [2:0]              kind;
  reg  [6:0]              shin;
  reg  [2:0]              bitc;
  reg  [1:0]              acnt;
  reg  [23:0]             addr;
  reg                     got_byte;
  reg                     extra_byte;
  reg                     cyc_lock;
  reg  [6:0]              shout;
  reg  [2:0]              obit;

  wire                    busy;
  wire                    tmr_done;
  reg                     tmr_start;

  wire       sck_rise = ck_s & ~ck_p;
  wire       sck_fall = ~ck_s & ck_p;
  // all select stages leave reset low, so a select held low through reset makes no fall
  wire       cs_fall  = ~cs_s & cs_p;
  wire       cs_rise  = cs_s & ~cs_p;
  wire       sel      = ~cs_s;
  wire [7:0] nb       = {shin, di_s};
  wire [23:0] nxa     = {addr[15:0], nb};
  wire [1:0] bp       = {protect_size_hi_i, protect_size_lo_i};
  wire [7:0] stat_byte = {status_lock_bit_i, 3'h0, bp, write_permit_latch_o, busy};
  wire [`SEWID_ARR_W-1:0] inc_page = {rd_addr_o[`SEWID_ARR_W-1:`SEWID_PAGE_W],
                                      rd_addr_o[`SEWID_PAGE_W-1:0] + 9'h001};
  reg  [7:0]              src;

  assign write_busy_flag_o = busy;
  assign miso_oe_o         = sel && (state == ST_RDOUT);

  sewid_wtimer #(
    .TW_CYC (TW_CYC)
  ) u_wtimer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (tmr_start),
    .busy_o    (busy),
    .erase_o   (wr_erase_o),
    .prog_o    (wr_prog_o),
    .done_o    (tmr_done)
  );

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      cs_m <= 1'b0;
      cs_s <= 1'b0;
      cs_p <= 1'b0;
      ck_m <= 1'b0;
      ck_s <= 1'b0;
      ck_p <= 1'b0;
      di_m <= 1'b0;
      di_s <= 1'b0;
    end else begin
      cs_m <= cs_n_i;
      cs_s <= cs_m;
      cs_p <= cs_s;
      ck_m <= sclk_i;
      ck_s <= ck_m;
      ck_p <= ck_s;
      di_m <= mosi_i;
      di_s <= di_m;
    end
  end

  // outgoing byte source
  always @* begin
    case (kind)
      K_LST:   src = {7'h00, id_locked_i};
      K_STAT:  src = stat_byte;
      default: src = rd_data_i;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      state                <= ST_IDLE;
      kind                 <= K_ARR;
      shin                 <= 7'h00;
      bitc                 <= 3'h0;
      acnt                 <= 2'h0;
      addr                 <= 24'h000000;
      got_byte             <= 1'b0;
      extra_byte           <= 1'b0;
      cyc_lock             <= 1'b0;
      shout                <= 7'h7f;
      obit                 <= 3'h0;
      miso_o               <= 1'b1;
      rd_id_o              <= 1'b0;
      rd_addr_o            <= {`SEWID_ARR_W{1'b0}};
      stg_valid_o          <= 1'b0;
      stg_id_o             <= 1'b0;
      stg_addr_o           <= {`SEWID_ARR_W{1'b0}};
      stg_group_o          <= {(`SEWID_ARR_W-2){1'b0}};
      stg_data_o           <= `SEWID_BLANK_BYTE;
      stg_abort_o          <= 1'b0;
      wr_commit_o          <= 1'b0;
      id_lock_set_o        <= 1'b0;
      tmr_start            <= 1'b0;
      write_permit_latch_o <= 1'b0;
    end else begin
      stg_valid_o   <= 1'b0;
      stg_abort_o   <= 1'b0;
      wr_commit_o   <= 1'b0;
      id_lock_set_o <= 1'b0;
      tmr_start     <= 1'b0;

      // end of any timed cycle drops the permit latch
      if (tmr_done) begin
        write_permit_latch_o <= 1'b0;
        id_lock_set_o        <= cyc_lock;
      end

      if (cs_fall) begin
        state    <= ST_OPC;
        bitc     <= 3'h0;
        acnt     <= 2'h0;
        obit     <= 3'h0;
        got_byte <= 1'b0;
        extra_byte <= 1'b0;
      end else if (cs_rise) begin
        state <= ST_IDLE;
        // an accepted write only runs when select rises on a byte boundary
        if (state == ST_WDATA) begin
          if (bitc == 3'h0 && got_byte && (kind != K_LOCK || !extra_byte)) begin
            wr_commit_o <= 1'b1;
            tmr_start   <= 1'b1;
            cyc_lock    <= (kind == K_LOCK);
          end else begin
            stg_abort_o <= got_byte;
          end
        end
      end else if (sel && sck_rise) begin
        shin <= nb[6:0];
        bitc <= bitc + 3'h1;
        if (bitc == `SEWID_BYTE_LAST) begin
          case (state)
            ST_OPC: begin
              state <= ST_SKIP;
              case (nb)
                `SEWID_OP_WPERMIT: begin
                  if (!busy)
                    write_permit_latch_o <= 1'b1;
                end
                `SEWID_OP_WFORBID: begin
                  if (!busy)
                    write_permit_latch_o <= 1'b0;
                end
                `SEWID_OP_RDSTAT: begin
                  kind  <= K_STAT;
                  state <= ST_RDOUT;
                end
                `SEWID_OP_WRITE: begin
                  kind <= K_ARR;
                  if (write_permit_latch_o && !busy)
                    state <= ST_ADDR;
                end
                `SEWID_OP_RDID: begin
                  kind <= K_IDR;
                  if (!busy)
                    state <= ST_ADDR;
                end
                `SEWID_OP_ID_PAGE_WRITE_CMD: begin
                  kind <= K_IDW;
                  if (write_permit_latch_o && !busy)
                    state <= ST_ADDR;
                end
                default: state <= ST_SKIP;
              endcase
            end
            ST_ADDR: begin
              addr <= nxa;
              acnt <= acnt + 2'h1;
              if (acnt == `SEWID_ADDR_BYTES) begin
                rd_addr_o <= nxa[`SEWID_ARR_W-1:0];
                case (kind)
                  K_ARR: begin
                    rd_id_o <= 1'b0;
                    // 19-bit address, top two bits pick the protected area
                    if (prot_hit(bp, nxa[`SEWID_TOP_HI:`SEWID_TOP_LO]))
                      state <= ST_SKIP;
                    else
                      state <= ST_WDATA;
                  end
                  K_IDW: begin
                    rd_id_o <= 1'b1;
                    rd_addr_o <= {10'h000, nxa[`SEWID_PAGE_W-1:0]};
                    if (nxa[`SEWID_ID_SEL_BIT]) begin
                      kind <= K_LOCK;
                      if (id_locked_i || bp == `SEWID_BP_ALL)
                        state <= ST_SKIP;
                      else
                        state <= ST_WDATA;
                    end else if (id_locked_i) begin
                      state <= ST_SKIP;
                    end else begin
                      state <= ST_WDATA;
                    end
                  end
                  default: begin
                    rd_id_o   <= 1'b1;
                    rd_addr_o <= {10'h000, nxa[`SEWID_PAGE_W-1:0]};
                    if (nxa[`SEWID_ID_SEL_BIT])
                      kind <= K_LST;
                    state <= ST_RDOUT;
                  end
                endcase
              end
            end
            ST_WDATA: begin
              extra_byte <= got_byte;
              got_byte   <= 1'b1;
              if (kind != K_LOCK) begin
                stg_valid_o <= 1'b1;
                stg_id_o    <= rd_id_o;
                stg_addr_o  <= rd_addr_o;
                stg_group_o <= rd_addr_o[`SEWID_ARR_W-1:`SEWID_GRP_LSB];
                stg_data_o  <= nb;
                rd_addr_o   <= inc_page;
              end
            end
            default: state <= state;
          endcase
        end
      end else if (sel && sck_fall && state == ST_RDOUT) begin
        // data shifts out on the falling edge, one bit per clock
        obit <= obit + 3'h1;
        if (obit == 3'h0) begin
          miso_o <= src[7];
          shout  <= src[6:0];
          if (kind == K_IDR)
            rd_addr_o <= rd_addr_o + 19'h00001;
        end else begin
          miso_o <= shout[6];
          shout  <= {shout[5:0], 1'b1};
        end
      end
    end
  end
endmodule

// *** core/sewid_map.vh ***
// constants of the spi eeprom write and identification page engine
`ifndef SEWID_MAP_VH
`define SEWID_MAP_VH

// clock and self-timed write time
`define SEWID_CLK_MHZ      200
`define SEWID_TW_MS        5
`define SEWID_TW_CYC       (`SEWID_TW_MS * `SEWID_CLK_MHZ * 1000)
`define SEWID_TW_W         24

// instruction codes, kept here so a derivative can change them in one place
`define SEWID_OP_WPERMIT   8'h06
`define SEWID_OP_WFORBID   8'h04
`define SEWID_OP_RDSTAT    8'h05
`define SEWID_OP_WRITE     8'h02
`define SEWID_OP_RDID      8'h83
`define SEWID_OP_ID_PAGE_WRITE_CMD      8'h82

// address layout
`define SEWID_ARR_W        19
`define SEWID_ADDR_BYTES   2'h2
`define SEWID_PAGE_W       9
`define SEWID_ID_SEL_BIT   10
`define SEWID_GRP_LSB      2
`define SEWID_TOP_HI       18
`define SEWID_TOP_LO       17

// protect-size codes
`define SEWID_BP_NONE      2'h0
`define SEWID_BP_QUARTER   2'h1
`define SEWID_BP_HALF      2'h2
`define SEWID_BP_ALL       2'h3

// delivery and idle values
`define SEWID_BLANK_BYTE   8'hff
`define SEWID_BYTE_LAST    3'h7

`endif

// *** core/sewid_wtimer.v ***
// self-timed write cycle: erase phase then program phase
`timescale 1ns/1ps
`include "sewid_map.vh"
module sewid_wtimer #(
  parameter [`SEWID_TW_W-1:0] TW_CYC = `SEWID_TW_CYC
) (
  // clock and reset
  input  wire ref_clk_i,
  input  wire rst_i,
  // control
  input  wire start_i,
  // cycle state
  output reg  busy_o,
  output wire erase_o,
  output wire prog_o,
  output reg  done_o
);
  localparam [`SEWID_TW_W-1:0] HALF = TW_CYC >> 1;
  localparam [`SEWID_TW_W-1:0] ONE  = {{(`SEWID_TW_W-1){1'b0}}, 1'b1};

  reg [`SEWID_TW_W-1:0] cnt;

  // first half clears the cells, second half sets the programmed ones
  assign erase_o = busy_o && (cnt < HALF);
  assign prog_o  = busy_o && (cnt >= HALF);

  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      cnt    <= {`SEWID_TW_W{1'b0}};
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (busy_o) begin
        if (cnt == TW_CYC - ONE) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        cnt <= cnt + ONE;
      end else if (start_i) begin
        busy_o <= 1'b1;
        cnt    <= {`SEWID_TW_W{1'b0}};
      end
    end
  end
endmodule

// *** dv/sewid_core_properties.sv ***
// assertions on the ports of the write and identification page engine
`timescale 1ns/1ps
`include "sewid_map.vh"
module sewid_core_props #(
  parameter [`SEWID_TW_W-1:0] TW_CYC = `SEWID_TW_CYC
) (
  // clock, reset, store lock state
  input wire                    ref_clk_i,
  input wire                    rst_i,
  input wire                    id_locked_i,
  // engine outputs
  input wire                    stg_valid_o,
  input wire [`SEWID_ARR_W-1:0] stg_addr_o,
  input wire [`SEWID_ARR_W-3:0] stg_group_o,
  input wire                    wr_commit_o,
  input wire                    wr_erase_o,
  input wire                    wr_prog_o,
  input wire                    id_lock_set_o,
  input wire                    write_busy_flag_o,
  input wire                    write_permit_latch_o
);
  reg [`SEWID_TW_W-1:0] busy_cnt;
  // length of the running write, judged when busy drops
  always @(posedge ref_clk_i) begin
    if (rst_i || !write_busy_flag_o)
      busy_cnt <= 'h0;
    else
      busy_cnt <= busy_cnt + 1'b1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_start; wr_commit_o |=> write_busy_flag_o; endproperty
  a_start: assert property (p_start)
    else $error("commit without busy");
  property p_len; $fell(write_busy_flag_o) |-> busy_cnt == TW_CYC; endproperty
  a_len: assert property (p_len)
    else $error("write time wrong");
  property p_wel; $fell(write_busy_flag_o) |=> !write_permit_latch_o; endproperty
  a_wel: assert property (p_wel)
    else $error("latch kept after write");
  property p_erase; $rose(wr_prog_o) |-> $past(wr_erase_o) && !wr_erase_o; endproperty
  a_erase: assert property (p_erase)
    else $error("program not after erase");
  property p_commit; wr_commit_o |-> write_permit_latch_o && !write_busy_flag_o; endproperty
  a_commit: assert property (p_commit)
    else $error("commit without latch");
  property p_stg; stg_valid_o |-> !write_busy_flag_o; endproperty
  a_stg: assert property (p_stg)
    else $error("byte taken while busy");
  property p_lock; id_lock_set_o |-> !id_locked_i && $past(write_busy_flag_o, 2); endproperty
  a_lock: assert property (p_lock)
    else $error("bad lock set");
  property p_grp; stg_valid_o |-> stg_group_o == stg_addr_o[`SEWID_ARR_W-1:2]; endproperty
  a_grp: assert property (p_grp)
    else $error("group not aligned");
endmodule
bind sewid_core sewid_core_props #(.TW_CYC(TW_CYC)) u_props (.ref_clk_i, .rst_i,
  .id_locked_i, .stg_valid_o, .stg_addr_o, .stg_group_o, .wr_commit_o, .wr_erase_o,
  .wr_prog_o, .id_lock_set_o, .write_busy_flag_o, .write_permit_latch_o);

// *** dv/sewid_host.sv ***
// spi host model: mode 0 frames with an 80 ns serial clock
`timescale 1ns/1ps
module sewid_host (
  // clock
  input  wire ref_clk_i,
  // spi pins
  output reg  cs_n_o = 1'b1,
  output reg  sclk_o = 1'b0,
  output reg  mosi_o = 1'b0,
  input  wire miso_i
);
  task tick(input integer n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // n bits msb first; the clock stands low between frames
  task shift(input [7:0] d, input integer n, output [7:0] q);
    integer i;
    begin
      q = 8'h00;
      for (i = 7; i > 7 - n; i = i - 1) begin
        mosi_o <= d[i];
        tick(8);
        sclk_o <= 1'b1;
        q[i] = miso_i;
        tick(8);
        sclk_o <= 1'b0;
      end
    end
  endtask
  task sel;
    begin
      cs_n_o <= 1'b0;
      tick(8);
    end
  endtask
  // select rises in the low phase, before any further clock rise
  task desel;
    begin
      tick(4);
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
      tick(12);
    end
  endtask
  task cmd(input [7:0] op, input [23:0] a);
    reg [7:0] q;
    begin
      sel;
      shift(op, 8, q);
      shift(a[23:16], 8, q);
      shift(a[15:8], 8, q);
      shift(a[7:0], 8, q);
    end
  endtask
endmodule

// *** dv/sewid_core_test.sv ***
// bench of the write and identification page engine
`timescale 1ns/1ps
`include "sewid_map.vh"
`define CMP(a, e) begin samples_checked = samples_checked + 1; if ((a) !== (e)) begin \
  fails = fails + 1; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module sewid_core_test;
  reg         ref_clk_i, rst_i, protect_size_hi_i, protect_size_lo_i;
  reg         status_lock_bit_i;
  reg         id_locked_i = 1'b0;
  wire        cs_n_i, sclk_i, mosi_i, miso_o, miso_oe_o, rd_id_o, stg_valid_o, stg_id_o;
  wire        stg_abort_o, wr_commit_o, wr_erase_o, wr_prog_o, id_lock_set_o;
  wire        write_busy_flag_o, write_permit_latch_o;
  wire [18:0] rd_addr_o, stg_addr_o;
  wire [16:0] stg_group_o;
  wire [7:0]  stg_data_o;
  // store model: fixed pattern, different in the identification page
  wire [7:0]  rd_data_i = rd_id_o ? rd_addr_o[7:0] ^ 8'h5a : rd_addr_o[7:0];
  integer     fails = 0, samples_checked = 0, n_stg = 0, n_com = 0, n_ab = 0;
  integer     c, m, i, k;
  reg [7:0]   q;
  reg [18:0]  log_a [0:7];
  reg [7:0]   log_d [0:7];
  sewid_core #(.TW_CYC(24'h000fa0)) dut (.ref_clk_i, .rst_i, .cs_n_i, .sclk_i, .mosi_i,
    .miso_o, .miso_oe_o, .protect_size_hi_i, .protect_size_lo_i, .status_lock_bit_i,
    .id_locked_i, .rd_id_o, .rd_addr_o, .rd_data_i, .stg_valid_o, .stg_id_o, .stg_addr_o,
    .stg_group_o, .stg_data_o, .stg_abort_o, .wr_commit_o, .wr_erase_o, .wr_prog_o,
    .id_lock_set_o, .write_busy_flag_o, .write_permit_latch_o);
  sewid_host h (.ref_clk_i, .cs_n_o(cs_n_i), .sclk_o(sclk_i), .mosi_o(mosi_i),
    .miso_i(miso_o));
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (stg_valid_o === 1'b1) begin
      log_a[n_stg % 8] = stg_addr_o;
      log_d[n_stg % 8] = stg_data_o;
      n_stg = n_stg + 1;
    end
    if (wr_commit_o === 1'b1) n_com = n_com + 1;
    if (stg_abort_o === 1'b1) n_ab = n_ab + 1;
    if (id_lock_set_o === 1'b1) id_locked_i <= 1'b1;
  end
  task op1(input [7:0] op);
    begin
      h.sel;
      h.shift(op, 8, q);
      h.desel;
    end
  endtask
  task frame(input [7:0] op, input [23:0] a, input [7:0] d);
    begin
      h.cmd(op, a);
      h.shift(d, 8, q);
      h.desel;
    end
  endtask
  task wait_idle;
    begin
      k = 0;
      while (write_busy_flag_o !== 1'b0 && k < 5000) begin
        @(posedge ref_clk_i);
        k = k + 1;
      end
      // the latch clear and the lock set follow the busy drop by a clock or two
      repeat (4) @(posedge ref_clk_i);
      `CMP(write_busy_flag_o, 1'b0)
      `CMP(write_permit_latch_o, 1'b0)
    end
  endtask
  task t_reset;
    begin
      // reset again with select held low: bits before the next select fall are ignored
      h.sel;
      rst_i <= 1'b1;
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      h.shift(`SEWID_OP_WPERMIT, 8, q);
      h.desel;
      `CMP(write_permit_latch_o, 1'b0)
      `CMP(write_permit_latch_o, 1'b0)
      `CMP(write_busy_flag_o, 1'b0)
      `CMP(miso_oe_o, 1'b0)
      c = n_stg;
      frame(`SEWID_OP_WRITE, 24'h000010, 8'h3c);
      `CMP(n_stg, c)
    end
  endtask
  task t_page;
    begin
      op1(`SEWID_OP_WPERMIT);
      `CMP(write_permit_latch_o, 1'b1)
      c = n_stg;
      m = n_com;
      h.cmd(`SEWID_OP_WRITE, 24'h0251fe);
      for (i = 0; i < 3; i = i + 1) h.shift(8'ha0 + i[7:0], 8, q);
      h.desel;
      `CMP(n_stg - c, 3)
      `CMP(n_com - m, 1)
      `CMP(write_busy_flag_o, 1'b1)
      for (i = 0; i < 3; i = i + 1) begin
        `CMP(log_a[(c + i) % 8], {10'h128, 9'h1fe + i[8:0]})
        `CMP(log_d[(c + i) % 8], 8'ha0 + i[7:0])
      end
      status_lock_bit_i <= 1'b1;
      h.sel;
      h.shift(`SEWID_OP_RDSTAT, 8, q);
      h.shift(8'h00, 8, q);
      h.desel;
      `CMP(q, 8'h83)
      c = n_stg;
      frame(`SEWID_OP_WRITE, 24'h000040, 8'h55);
      `CMP(n_stg, c)
      h.cmd(`SEWID_OP_RDID, 24'h000000);
      h.shift(8'h00, 8, q);
      `CMP(miso_oe_o, 1'b0)
      h.desel;
      wait_idle;
    end
  endtask
  task t_abort;
    begin
      op1(`SEWID_OP_WPERMIT);
      c = n_ab;
      m = n_com;
      h.cmd(`SEWID_OP_WRITE, 24'h000020);
      h.shift(8'h11, 8, q);
      h.shift(8'h22, 3, q);
      h.desel;
      `CMP(n_ab - c, 1)
      `CMP(n_com, m)
    end
  endtask
  task t_protect;
    begin
      op1(`SEWID_OP_WPERMIT);
      protect_size_lo_i <= 1'b1;
      c = n_stg;
      frame(`SEWID_OP_WRITE, 24'h070000, 8'h33);
      `CMP(n_stg, c)
      `CMP(n_com, m)
      protect_size_lo_i <= 1'b0;
      op1(`SEWID_OP_WFORBID);
      `CMP(write_permit_latch_o, 1'b0)
    end
  endtask
  task t_id;
    begin
      h.cmd(`SEWID_OP_RDID, 24'hf981fd);
      h.shift(8'h00, 8, q);
      `CMP(q, 8'ha7)
      `CMP(miso_oe_o, 1'b1)
      h.shift(8'h00, 8, q);
      `CMP(q, 8'ha4)
      h.shift(8'h00, 5, q);
      h.desel;
      `CMP(miso_oe_o, 1'b0)
      op1(`SEWID_OP_WPERMIT);
      m = n_com;
      frame(`SEWID_OP_ID_PAGE_WRITE_CMD, 24'hfe8003, 8'h77);
      `CMP(stg_id_o, 1'b1)
      `CMP(stg_addr_o[8:0], 9'h003)
      `CMP(stg_data_o, 8'h77)
      `CMP(n_com - m, 1)
      wait_idle;
    end
  endtask
  task t_lock;
    begin
      h.cmd(`SEWID_OP_RDID, 24'h000400);
      h.shift(8'h00, 8, q);
      h.desel;
      `CMP(q, 8'h00)
      m = n_com;
      frame(`SEWID_OP_ID_PAGE_WRITE_CMD, 24'h000400, 8'h01);
      `CMP(n_com, m)
      {protect_size_hi_i, protect_size_lo_i} <= 2'h3;
      op1(`SEWID_OP_WPERMIT);
      frame(`SEWID_OP_ID_PAGE_WRITE_CMD, 24'h000400, 8'h01);
      `CMP(n_com, m)
      {protect_size_hi_i, protect_size_lo_i} <= 2'h0;
      frame(`SEWID_OP_ID_PAGE_WRITE_CMD, 24'h000400, 8'h01);
      `CMP(n_com - m, 1)
      wait_idle;
      `CMP(id_locked_i, 1'b1)
      h.cmd(`SEWID_OP_RDID, 24'h000400);
      h.shift(8'h00, 8, q);
      h.shift(8'h00, 8, q);
      h.desel;
      `CMP(q, 8'h01)
      op1(`SEWID_OP_WPERMIT);
      frame(`SEWID_OP_ID_PAGE_WRITE_CMD, 24'h000400, 8'h01);
      c = n_stg;
      frame(`SEWID_OP_ID_PAGE_WRITE_CMD, 24'h000010, 8'h66);
      `CMP(n_com, m + 1)
      `CMP(n_stg, c)
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    rst_i = 1'b1;
    protect_size_hi_i = 1'b0;
    protect_size_lo_i = 1'b0;
    status_lock_bit_i = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    t_reset;
    t_page;
    t_abort;
    t_protect;
    t_id;
    t_lock;
    end_of_test;
  end
  // about three and a half times the expected run
  initial begin
    #400000;
    fails = fails + 1;
    end_of_test;
  end
endmodule
